//--- hw/dfi_byte_if.sv
// Byte carrier between the serial receiver and the command sequencer.
// Assumes both ends share the core clock; valid is a one-cycle pulse.
`timescale 1ns/1ps
interface dfi_byte_if;
  logic [7:0] data; // Received byte, MSB first on the wire
  logic valid; // One-cycle strobe per complete access
  modport rx (output data, output valid);
  modport cmd (input data, input valid);
endinterface

//--- hw/dfi_cmd_top.sv
// Command sequencer of the matrix display: fills, invert, luminance and self-test.
// Assumes a host driving mode 0 serial pins and a panel scanner reading words by row and column.
`timescale 1ns/1ps
// Operation
// - Code 11 clears every frame memory bit
// - Code 12 sets every frame memory bit
// - Invert changes displayed picture, not memory
// - Each invert command toggles one inversion state
// - Codes 81-84 select 100/75/50/30 percent luminance
// - Self-test alternates full-on and checkerboard, minute each
// - Self-test runs from power-on until first byte
// - Grounded strap at start-up skips self-test
// - Luminance starts at full 100 percent
// - Access is select-framed, eight bits, mode 0
module dfi_cmd_top #(
  parameter int FRAME_CYC_100 = dfi_pkg::FRAME_100_CYC,
  parameter longint ST_CYC = dfi_pkg::ST_CYC
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic SPI_SCLK_I,
  input wire logic SPI_MOSI_I,
  input wire logic SPI_SS_N_I,
  input wire logic SELF_TEST_STRAP_I,
  input wire logic [5:0] SCAN_ROW_I,
  input wire logic [3:0] SCAN_COL_I,
  output logic [15:0] SCAN_DATA_O,
  output logic INVERT_O,
  output logic [1:0] LUMA_SEL_O,
  output logic FRAME_TICK_O,
  output logic SELF_TEST_O,
  output logic FILL_BUSY_O
);
  localparam logic [33:0] ST_CNT_LAST = 34'(ST_CYC - 1);

  dfi_byte_if rx_bus ();

  dfi_spi_rx u_rx (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .sclk_i(SPI_SCLK_I),
    .mosi_i(SPI_MOSI_I),
    .ss_n_i(SPI_SS_N_I),
    .rx(rx_bus)
  );

  // Known command codes
  function automatic logic cmd_known(input logic [7:0] b);
    return b inside {dfi_pkg::CMD_CLEAR, dfi_pkg::CMD_ALL_ON, dfi_pkg::CMD_INVERT, dfi_pkg::CMD_LUM100,
      dfi_pkg::CMD_LUM75, dfi_pkg::CMD_LUM50, dfi_pkg::CMD_LUM30};
  endfunction

  // Luminance codes form a run starting at the full level
  function automatic logic is_luma(input logic [7:0] b);
    return b inside {dfi_pkg::CMD_LUM100, dfi_pkg::CMD_LUM75, dfi_pkg::CMD_LUM50, dfi_pkg::CMD_LUM30};
  endfunction

  function automatic logic [1:0] luma_code(input logic [7:0] b);
    logic [7:0] d;
    d = b - dfi_pkg::CMD_LUM100;
    return d[1:0];
  endfunction

  // Frame length grows as luminance drops: a slower frame gives less light
  function automatic logic [31:0] frame_len(input logic [1:0] l);
    int pct;
    unique case (l)
      dfi_pkg::LUMA_100: pct = dfi_pkg::PCT_100;
      dfi_pkg::LUMA_75: pct = dfi_pkg::PCT_75;
      dfi_pkg::LUMA_50: pct = dfi_pkg::PCT_50;
      dfi_pkg::LUMA_30: pct = dfi_pkg::PCT_30;
    endcase
    return 32'((longint'(FRAME_CYC_100) * dfi_pkg::PCT_100) / pct);
  endfunction

  // Strap sync: stage zero feeds stage one only
  logic [2:0] strap_sync, next_strap_sync;
  logic strap_filt, next_strap_filt;

  always_comb
  begin
    next_strap_sync = {strap_sync[1:0], SELF_TEST_STRAP_I};
    next_strap_filt = (strap_sync[1] == strap_sync[2]) ? strap_sync[2] : strap_filt;
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      strap_sync <= 3'h0;
      strap_filt <= 1'b0;
    end
    else
    begin
      strap_sync <= next_strap_sync;
      strap_filt <= next_strap_filt;
    end
  end

  // Self-test group: the strap is taken a few cycles after release, once the sync has settled
  logic [2:0] st_wait, next_st_wait;
  logic st_latched, next_st_latched; // Strap has been taken
  logic st_on, next_st_on; // Self-test patterns on display
  logic st_phase, next_st_phase; // Low: full on, high: checkerboard
  logic [33:0] st_cnt, next_st_cnt; // Dwell counter for the current pattern

  always_comb
  begin
    next_st_wait = st_wait;
    next_st_latched = st_latched;
    next_st_on = st_on;
    next_st_phase = st_phase;
    next_st_cnt = st_cnt;
    if (!st_latched)
    begin
      if (st_wait == dfi_pkg::STRAP_WAIT_LAST || rx_bus.valid)
      begin
        next_st_latched = 1'b1;
        next_st_on = strap_filt && !rx_bus.valid;
      end
      else
      begin
        next_st_wait = st_wait + 3'h1;
      end
    end
    else if (st_on)
    begin
      // Once off, nothing turns self-test back on until the next reset
      if (rx_bus.valid)
      begin
        next_st_on = 1'b0;
      end
      else if (st_cnt == ST_CNT_LAST)
      begin
        next_st_cnt = 34'h0;
        next_st_phase = ~st_phase;
      end
      else
      begin
        next_st_cnt = st_cnt + 34'h1;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      st_wait <= 3'h0;
      st_latched <= 1'b0;
      st_on <= 1'b0;
      st_phase <= 1'b0;
      st_cnt <= 34'h0;
    end
    else
    begin
      st_wait <= next_st_wait;
      st_latched <= next_st_latched;
      st_on <= next_st_on;
      st_phase <= next_st_phase;
      st_cnt <= next_st_cnt;
    end
  end

  // Command group: fill sweep, inversion and luminance
  dfi_pkg::dfi_state_t state, next_state;
  logic [9:0] fill_addr, next_fill_addr;
  logic fill_val, next_fill_val; // Bit value written by the sweep
  logic invert, next_invert;
  logic [1:0] luma, next_luma;
  logic luma_seen, next_luma_seen; // A luminance command has arrived
  logic mem_we;

  always_comb
  begin
    next_state = state;
    next_fill_addr = fill_addr;
    next_fill_val = fill_val;
    next_invert = invert;
    next_luma = luma;
    next_luma_seen = luma_seen;
    unique case (state)
      dfi_pkg::DFI_IDLE: ;
      dfi_pkg::DFI_FILL:
      begin
        next_fill_addr = fill_addr + 10'h001;
        if (fill_addr == dfi_pkg::FILL_LAST)
        begin
          next_state = dfi_pkg::DFI_IDLE;
        end
      end
    endcase
    // A new fill restarts the sweep from word zero with the new value
    if (rx_bus.valid)
    begin
      if (rx_bus.data == dfi_pkg::CMD_CLEAR)
      begin
        next_state = dfi_pkg::DFI_FILL;
        next_fill_addr = 10'h000;
        next_fill_val = 1'b0;
      end
      else if (rx_bus.data == dfi_pkg::CMD_ALL_ON)
      begin
        next_state = dfi_pkg::DFI_FILL;
        next_fill_addr = 10'h000;
        next_fill_val = 1'b1;
      end
      else if (rx_bus.data == dfi_pkg::CMD_INVERT)
      begin
        next_invert = ~invert;
      end
      else if (is_luma(rx_bus.data))
      begin
        next_luma = luma_code(rx_bus.data);
        next_luma_seen = 1'b1;
      end
      // Anything else falls through untouched
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state <= dfi_pkg::DFI_IDLE;
      fill_addr <= 10'h000;
      fill_val <= 1'b0;
      invert <= 1'b0;
      luma <= dfi_pkg::LUMA_RESET;
      luma_seen <= 1'b0;
    end
    else
    begin
      state <= next_state;
      fill_addr <= next_fill_addr;
      fill_val <= next_fill_val;
      invert <= next_invert;
      luma <= next_luma;
      luma_seen <= next_luma_seen;
    end
  end

  // Frame memory: only the fill sweep writes it; it has no reset, so it holds garbage until filled
  logic [15:0] mem [0:dfi_pkg::MEM_WORDS-1];
  assign mem_we = (state == dfi_pkg::DFI_FILL);

  always_ff @(posedge CORE_CLK_I)
  begin
    if (mem_we)
    begin
      mem[fill_addr] <= {dfi_pkg::WORD_W{fill_val}};
    end
  end

  // Scan output: self-test patterns override memory; inversion acts only here
  logic [9:0] scan_addr;
  logic [15:0] scan_data, next_scan_data;
  assign scan_addr = 10'(int'(SCAN_ROW_I) * dfi_pkg::ROW_WORDS + int'(SCAN_COL_I));

  always_comb
  begin
    next_scan_data = 16'h0000;
    if (st_on)
    begin
      next_scan_data = !st_phase ? dfi_pkg::FULL_ON : (SCAN_ROW_I[0] ? dfi_pkg::CHECK_ODD : dfi_pkg::CHECK_EVEN);
    end
    else if (int'(scan_addr) < dfi_pkg::MEM_WORDS)
    begin
      next_scan_data = mem[scan_addr] ^ {dfi_pkg::WORD_W{invert}};
    end
  end

  // Frame divider: luminance sets the frame period
  logic [31:0] frame_cnt, next_frame_cnt;
  logic frame_tick, next_frame_tick;

  always_comb
  begin
    next_frame_cnt = frame_cnt + 32'h1;
    next_frame_tick = 1'b0;
    // Compare with >= so a shorter period after a change takes effect at once
    if (frame_cnt >= frame_len(luma) - 32'h1)
    begin
      next_frame_cnt = 32'h0;
      next_frame_tick = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      scan_data <= 16'h0000;
      frame_cnt <= 32'h0;
      frame_tick <= 1'b0;
    end
    else
    begin
      scan_data <= next_scan_data;
      frame_cnt <= next_frame_cnt;
      frame_tick <= next_frame_tick;
    end
  end

  assign SCAN_DATA_O = scan_data;
  assign INVERT_O = invert;
  assign LUMA_SEL_O = luma;
  assign FRAME_TICK_O = frame_tick;
  assign SELF_TEST_O = st_on;
  assign FILL_BUSY_O = mem_we;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_cmd(logic [7:0] c);
    rx_bus.valid && rx_bus.data == c;
  endsequence
  sequence s_sweep_start(logic v);
    (mem_we && fill_val == v && fill_addr == 10'h000) ##1 (mem_we && fill_addr == 10'h001);
  endsequence

  AST_CLEAR_FILL: assert property (s_cmd(dfi_pkg::CMD_CLEAR) |=> s_sweep_start(1'b0))
    else $error("clear did not start a zero sweep");
  AST_ON_FILL: assert property (s_cmd(dfi_pkg::CMD_ALL_ON) |=> s_sweep_start(1'b1))
    else $error("all-on did not start a ones sweep");
  AST_FILL_DONE: assert property (mem_we && fill_addr == dfi_pkg::FILL_LAST && !rx_bus.valid |=> !mem_we)
    else $error("sweep did not stop at the last word");
  AST_INV_NO_WRITE: assert property (rx_bus.valid && rx_bus.data == dfi_pkg::CMD_INVERT && !mem_we |=> !mem_we)
    else $error("invert wrote frame memory");
  AST_INV_TOGGLE: assert property (s_cmd(dfi_pkg::CMD_INVERT) |=> invert != $past(invert))
    else $error("invert state did not toggle");
  AST_LUMA_SET: assert property (rx_bus.valid && is_luma(rx_bus.data) |=> luma == luma_code($past(rx_bus.data)))
    else $error("luminance code not taken");
  AST_ST_PHASE: assert property (st_on && st_cnt == ST_CNT_LAST && !rx_bus.valid |=> st_phase != $past(st_phase))
    else $error("self-test pattern did not alternate");
  AST_ST_END: assert property (st_on && rx_bus.valid |=> !st_on [*3])
    else $error("self-test outlived first byte");
  AST_STRAP_LOW: assert property (!st_latched && !strap_filt |=> !st_on)
    else $error("self-test started with grounded strap");
  AST_LUMA_DEFAULT: assert property (!luma_seen |-> luma == dfi_pkg::LUMA_RESET)
    else $error("luminance left full level without a command");
  AST_UNKNOWN: assert property (rx_bus.valid && !cmd_known(rx_bus.data) && !mem_we
    |=> $stable(invert) && $stable(luma) && !mem_we)
    else $error("unknown code changed state");
endmodule

//--- hw/dfi_pkg.sv
// Constants, command codes and state types shared by the display command block.
// Assumes a single 125 MHz core clock; the frame and self-test cycle counts are derived from it here.
package dfi_pkg;
  // Core clock rate
  localparam int CLK_HZ = 125_000_000;
  // Command codes seen on the serial port
  localparam logic [7:0] CMD_CLEAR = 8'h11;
  localparam logic [7:0] CMD_ALL_ON = 8'h12;
  localparam logic [7:0] CMD_INVERT = 8'h13;
  localparam logic [7:0] CMD_LUM100 = 8'h81;
  localparam logic [7:0] CMD_LUM75 = 8'h82;
  localparam logic [7:0] CMD_LUM50 = 8'h83;
  localparam logic [7:0] CMD_LUM30 = 8'h84;
  // Frame memory geometry: 60 lines of 160 pixels, 16 pixels to a word
  localparam int ROW_PIX = 160;
  localparam int ROWS = 60;
  localparam int WORD_W = 16;
  localparam int ROW_WORDS = ROW_PIX / WORD_W;
  localparam int MEM_WORDS = ROWS * ROW_WORDS;
  localparam int ADDR_W = 10;
  localparam logic [9:0] FILL_LAST = 10'(MEM_WORDS - 1);
  // Checkerboard words for even and odd lines, and the full-on word
  localparam logic [15:0] CHECK_EVEN = 16'hAAAA;
  localparam logic [15:0] CHECK_ODD = 16'h5555;
  localparam logic [15:0] FULL_ON = 16'hFFFF;
  // Luminance codes and their relative levels in percent
  localparam logic [1:0] LUMA_100 = 2'h0;
  localparam logic [1:0] LUMA_75 = 2'h1;
  localparam logic [1:0] LUMA_50 = 2'h2;
  localparam logic [1:0] LUMA_30 = 2'h3;
  localparam logic [1:0] LUMA_RESET = LUMA_100;
  localparam int PCT_100 = 100;
  localparam int PCT_75 = 75;
  localparam int PCT_50 = 50;
  localparam int PCT_30 = 30;
  // Frame period at full luminance, in microseconds, and in cycles
  localparam int FRAME_100_US = 10_000;
  localparam int FRAME_100_CYC = FRAME_100_US * (CLK_HZ / 1_000_000);
  // Self-test pattern dwell, in seconds, and in cycles
  localparam int ST_TIME_S = 60;
  localparam longint ST_CYC = longint'(ST_TIME_S) * longint'(CLK_HZ);
  // Cycles after reset release before the strap is taken
  // The sync and filter need four edges to show the pin, so taking it sooner would always read low
  localparam logic [2:0] STRAP_WAIT_LAST = 3'h5;
  // Serial framing
  localparam logic [3:0] SPI_BITS = 4'h8;
  localparam logic [3:0] SPI_CNT_MAX = 4'h9;
  // Pin sync reset value, order {ss_n, mosi, sclk}: select idle high
  localparam logic [2:0] PIN_RST = 3'h4;
  // Command sequencer states
  typedef enum logic [1:0] {DFI_IDLE = 2'b01, DFI_FILL = 2'b10} dfi_state_t;
endpackage

//--- hw/dfi_spi_rx.sv
// Mode 0 serial byte receiver, oversampled on the core clock.
// Assumes the serial pins are asynchronous and each phase lasts well over 3 core cycles.
`timescale 1ns/1ps
module dfi_spi_rx (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic mosi_i,
  input wire logic ss_n_i,
  dfi_byte_if.rx rx
);
  logic [2:0] s1, s2, s3; // Three-stage sync, order {ss_n, mosi, sclk}
  logic [2:0] filt, filt_d; // Filtered levels and their previous value
  logic [2:0] next_s1, next_s2, next_s3, next_filt, next_filt_d;
  logic [7:0] shift, next_shift; // Bits shifted in, MSB first
  logic [3:0] bit_cnt, next_bit_cnt; // Bits in the current access, saturating
  logic [7:0] data, next_data;
  logic valid, next_valid;
  logic sclk_rise, ss_fall, ss_rise;

  // Sync and filter: a level only changes once stages two and three agree
  always_comb
  begin
    next_s1 = {ss_n_i, mosi_i, sclk_i};
    next_s2 = s1;
    next_s3 = s2;
    next_filt = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);
    next_filt_d = filt;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1 <= dfi_pkg::PIN_RST;
      s2 <= dfi_pkg::PIN_RST;
      s3 <= dfi_pkg::PIN_RST;
      filt <= dfi_pkg::PIN_RST;
      filt_d <= dfi_pkg::PIN_RST;
    end
    else
    begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
      filt <= next_filt;
      filt_d <= next_filt_d;
    end
  end

  // Edges of the filtered clock and select
  assign sclk_rise = filt[0] & ~filt_d[0];
  assign ss_fall = ~filt[2] & filt_d[2];
  assign ss_rise = filt[2] & ~filt_d[2];

  // Shifter: sample on rising clock, deliver only an access of exactly eight bits
  always_comb
  begin
    next_shift = shift;
    next_bit_cnt = bit_cnt;
    next_data = data;
    next_valid = 1'b0;
    if (ss_fall)
    begin
      next_bit_cnt = 4'h0;
    end
    else if (sclk_rise && !filt[2])
    begin
      next_shift = {shift[6:0], filt[1]};
      // Saturate so a long access is still seen as too long
      if (bit_cnt != dfi_pkg::SPI_CNT_MAX)
      begin
        next_bit_cnt = bit_cnt + 4'h1;
      end
    end
    if (ss_rise && bit_cnt == dfi_pkg::SPI_BITS)
    begin
      next_valid = 1'b1;
      next_data = shift;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      data <= 8'h00;
      valid <= 1'b0;
    end
    else
    begin
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      data <= next_data;
      valid <= next_valid;
    end
  end

  assign rx.data = data;
  assign rx.valid = valid;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_BYTE_EIGHT: assert property (valid |-> bit_cnt == dfi_pkg::SPI_BITS && $past(ss_rise))
    else $error("byte delivered without exactly eight bits");
  AST_BIT_COUNT: assert property ((sclk_rise && !filt[2] && !ss_fall && bit_cnt < dfi_pkg::SPI_BITS)
    |=> bit_cnt == $past(bit_cnt) + 4'h1)
    else $error("bit counter did not advance on clock rise");
endmodule

//--- test/dfi_spi_host.sv
// Host model for the serial command port: mode 0 master, one byte per select frame.
// Assumes the core clock as time base; each clock phase lasts HALF core cycles.
`timescale 1ns/1ps
module dfi_spi_host #(
  parameter int HALF = 16
) (
  input wire logic clk_i,
  output logic sclk_o,
  output logic mosi_o,
  output logic ss_n_o
);
  // Idle: clock low, select high
  initial
  begin
    sclk_o = 1'b0;
    mosi_o = 1'b0;
    ss_n_o = 1'b1;
  end

  // Wait n core edges, then the fixed drive delay
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // One access; nbits below 8 makes a short, malformed frame
  task automatic send(input logic [7:0] b, input int nbits);
    ss_n_o = 1'b0;
    wt(HALF);
    for (int i = 0; i < nbits; i++)
    begin
      // Data set on the falling side, taken at the rise: mode 0, MSB first
      mosi_o = b[7-i];
      wt(HALF);
      sclk_o = 1'b1;
      wt(HALF);
      sclk_o = 1'b0;
    end
    wt(HALF);
    ss_n_o = 1'b1;
    // Released data line shows no stale bit
    mosi_o = ~mosi_o;
    wt(HALF);
  endtask
endmodule

//--- test/testbench.sv
// Self-checking bench for the display command sequencer.
// Assumes short self-test and frame counts set by parameter; the host model drives the serial pins.
`timescale 1ns/1ps
module testbench;
  localparam int FRC = 20; // Shortened full-luminance frame
  localparam longint STC = 64; // Shortened self-test dwell
  localparam int CEIL = 30000; // Cycle ceiling for a hung run
  logic core_clk;
  logic rst;
  logic strap;
  logic [5:0] scan_row;
  logic [3:0] scan_col;
  logic spi_sclk;
  logic spi_mosi;
  logic spi_ss_n;
  logic [15:0] scan_data;
  logic invert;
  logic [1:0] luma_sel;
  logic frame_tick;
  logic self_test;
  logic fill_busy;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int p;
  int n;
  logic [15:0] prev;
  int run;
  int chg;
  logic [7:0] lcode [4] = '{dfi_pkg::CMD_LUM100, dfi_pkg::CMD_LUM75, dfi_pkg::CMD_LUM50, dfi_pkg::CMD_LUM30};
  int lpct [4] = '{dfi_pkg::PCT_100, dfi_pkg::PCT_75, dfi_pkg::PCT_50, dfi_pkg::PCT_30};

  dfi_cmd_top #(.FRAME_CYC_100(FRC), .ST_CYC(STC)) dut_u (
    .CORE_CLK_I(core_clk), .RST_I(rst), .SPI_SCLK_I(spi_sclk), .SPI_MOSI_I(spi_mosi),
    .SPI_SS_N_I(spi_ss_n), .SELF_TEST_STRAP_I(strap), .SCAN_ROW_I(scan_row), .SCAN_COL_I(scan_col),
    .SCAN_DATA_O(scan_data), .INVERT_O(invert), .LUMA_SEL_O(luma_sel), .FRAME_TICK_O(frame_tick),
    .SELF_TEST_O(self_test), .FILL_BUSY_O(fill_busy)
  );

  dfi_spi_host #(.HALF(16)) host_u (.clk_i(core_clk), .sclk_o(spi_sclk), .mosi_o(spi_mosi), .ss_n_o(spi_ss_n));

  // Free-running 125 MHz clock
  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;

  // Verdict and end of run, the only exit
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Hang guard: a run past the ceiling counts as a mismatch
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == CEIL)
    begin
      err_count++;
      $display("mismatch timeout expected %0d seen %0d", CEIL - 1, cyc);
      tally_and_finish();
    end
  end

  // Step k edges, then the fixed drive delay
  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  // Compare one value, four-state
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Scan read: word registered at the first edge after the address, checked one edge later
  task automatic rd(input logic [5:0] r, input logic [3:0] c, input logic [15:0] e);
    scan_row = r;
    scan_col = c;
    step(2);
    chk("scan_data", e, scan_data);
  endtask

  // First and last lines and words of the frame memory
  task automatic corners(input logic [15:0] e);
    rd(6'h00, 4'h0, e);
    rd(6'h00, 4'h9, e);
    rd(6'h3B, 4'h0, e);
    rd(6'h3B, 4'h9, e);
  endtask

  // Single-byte command, then time for it to take effect
  task automatic cmd(input logic [7:0] b);
    host_u.send(b, 8);
    step(4);
  endtask

  // Fill command: the sweep must run once over every memory word
  // The sweep starts before the host finishes its trailing idle, so the count runs alongside the send
  task automatic fill(input logic [7:0] b);
    int i;
    i = 0;
    n = 0;
    fork
      host_u.send(b, 8);
      begin
        while (fill_busy !== 1'b1 && i < 600)
        begin
          step(1);
          i++;
        end
        while (fill_busy === 1'b1 && n < 2000)
        begin
          step(1);
          n++;
        end
      end
    join
    chk("fill_len", 16'(dfi_pkg::MEM_WORDS), 16'(n));
  endtask

  // Cycles from one frame tick to the next, after settling on a fresh frame
  task automatic period(output int q);
    int k;
    for (int j = 0; j < 3; j++)
    begin
      k = 0;
      do
      begin
        step(1);
        k++;
      end while (frame_tick !== 1'b1 && k < 300);
    end
    q = k;
  endtask

  // Main sequence
  initial
  begin
    rst = 1'b1;
    strap = 1'b1;
    scan_row = 6'h00;
    scan_col = 4'h0;
    step(5);
    rst = 1'b0;
    chk("luma_rst", 16'(dfi_pkg::LUMA_RESET), 16'(luma_sel));
    chk("invert_rst", 16'h0000, 16'(invert));
    step(10);
    chk("self_test_on", 16'h0001, 16'(self_test));
    // Watch line 0: only full-on and even checkerboard, each for the whole dwell
    prev = scan_data;
    run = 0;
    chg = 0;
    repeat (300)
    begin
      step(1);
      if (scan_data !== dfi_pkg::FULL_ON && scan_data !== dfi_pkg::CHECK_EVEN)
        chk("st_pattern", dfi_pkg::FULL_ON, scan_data);
      if (scan_data !== prev)
      begin
        if (chg > 0)
          chk("st_dwell", 16'(STC), 16'(run));
        chg++;
        run = 0;
        prev = scan_data;
      end
      run++;
    end
    chk("st_changes", 16'h0001, 16'(chg >= 3));
    rd(6'h01, 4'h0, prev == dfi_pkg::FULL_ON ? dfi_pkg::FULL_ON : dfi_pkg::CHECK_ODD);
    // Move into the checkerboard dwell to see the odd line pattern
    step(20);
    rd(6'h01, 4'h0, dfi_pkg::CHECK_ODD);
    // Short frame is dropped: self-test and inversion stay
    host_u.send(dfi_pkg::CMD_INVERT, 7);
    step(8);
    chk("short_st", 16'h0001, 16'(self_test));
    chk("short_inv", 16'h0000, 16'(invert));
    // Unknown code ends self-test and changes nothing else
    cmd(8'h00);
    chk("st_end", 16'h0000, 16'(self_test));
    chk("unk_inv", 16'h0000, 16'(invert));
    chk("unk_luma", 16'(dfi_pkg::LUMA_100), 16'(luma_sel));
    period(p);
    chk("frame_100", 16'(FRC), 16'(p));
    fill(dfi_pkg::CMD_ALL_ON);
    corners(dfi_pkg::FULL_ON);
    cmd(dfi_pkg::CMD_INVERT);
    chk("inv_on", 16'h0001, 16'(invert));
    rd(6'h1E, 4'h5, 16'h0000);
    fill(dfi_pkg::CMD_CLEAR);
    corners(dfi_pkg::FULL_ON);
    cmd(dfi_pkg::CMD_INVERT);
    chk("inv_off", 16'h0000, 16'(invert));
    corners(16'h0000);
    // Every luminance code: selection and frame period scaled 100/pct
    for (int i = 0; i < 4; i++)
    begin
      cmd(lcode[i]);
      chk("luma_sel", 16'(i), 16'(luma_sel));
      period(p);
      chk("frame_len", 16'(FRC * 100 / lpct[i]), 16'(p));
    end
    // Second reset with the strap grounded
    cmd(dfi_pkg::CMD_INVERT);
    rst = 1'b1;
    strap = 1'b0;
    step(5);
    rst = 1'b0;
    chk("luma_rst2", 16'(dfi_pkg::LUMA_RESET), 16'(luma_sel));
    chk("invert_rst2", 16'h0000, 16'(invert));
    step(20);
    chk("st_skip", 16'h0000, 16'(self_test));
    tally_and_finish();
  end
endmodule
